// [logic/sio_sram.sv]
// link front end of a separate-port two-word burst sram
`timescale 1ns/1ps
`default_nettype none
module sio_sram #(
    parameter int WORD_W = sio_pkg::WORD_W_DEF,
    parameter int ADDR_W = sio_pkg::addr_w_for(WORD_W)
) (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // input and output clock pairs from the controller
    input  wire logic              in_clk_i,
    input  wire logic              in_clk_n_i,
    input  wire logic              out_clk_i,
    input  wire logic              out_clk_n_i,
    input  wire logic              single_clk_mode_i,
    // shared address bus and requests
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              rd_req_n_i,
    input  wire logic              wr_req_n_i,
    // write data in
    input  wire logic [WORD_W-1:0] wdata_i,
    // read data out and echo clocks
    output logic      [WORD_W-1:0] rdata_o,
    output logic                   rdata_valid_o,
    output logic                   echo_clock_o,
    output logic                   echo_clock_complement_o
);
    // =====================================================================
    // input sampling
    localparam int LW = sio_pkg::LK_W;
    localparam int BW = ADDR_W + WORD_W + 2;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001, WR_D0 = 3'b010, WR_D1 = 3'b100
    } sio_wr_e;
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001, RD_W0 = 3'b010, RD_W1 = 3'b100
    } sio_rd_e;

    // a clean rising edge: filtered low, last two stages agree high
    function automatic logic rise(input logic f, input logic s2, input logic s3);
        return !f && s2 && s3;
    endfunction

    logic [LW-1:0] lk_s1_q, lk_s2_q, lk_s3_q, lk_f_q, lk_f_d, lk_rise;
    logic [BW-1:0] bus_s1_q, bus_s2_q, bus_s3_q;

    // three stage sampling of every pin into the core clock domain
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lk_s1_q  <= sio_pkg::LK_IDLE;
            lk_s2_q  <= sio_pkg::LK_IDLE;
            lk_s3_q  <= sio_pkg::LK_IDLE;
            bus_s1_q <= '0;
            bus_s2_q <= '0;
            bus_s3_q <= '0;
        end else begin
            lk_s1_q  <= {single_clk_mode_i, out_clk_n_i, out_clk_i, in_clk_n_i, in_clk_i};
            lk_s2_q  <= lk_s1_q;
            lk_s3_q  <= lk_s2_q;
            bus_s1_q <= {rd_req_n_i, wr_req_n_i, addr_i, wdata_i};
            bus_s2_q <= bus_s1_q;
            bus_s3_q <= bus_s2_q;
        end
    end

    // filtered levels and rising edge detect per link line
    generate
        for (genvar i = 0; i < LW; i++) begin : g_edge
            assign lk_f_d[i]  = (lk_s2_q[i] == lk_s3_q[i]) ? lk_s3_q[i] : lk_f_q[i];
            assign lk_rise[i] = rise(lk_f_q[i], lk_s2_q[i], lk_s3_q[i]);
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lk_f_q <= sio_pkg::LK_IDLE;
        end else begin
            lk_f_q <= lk_f_d;
        end
    end

    logic              k_rise, kn_rise, single, launch_rise, launch_n_rise, launch_lvl;
    logic [WORD_W-1:0] din;
    logic [ADDR_W-1:0] ain;
    logic              rd_req, wr_req;

    assign k_rise        = lk_rise[sio_pkg::LK_K];
    assign kn_rise       = lk_rise[sio_pkg::LK_KN];
    assign single        = lk_f_q[sio_pkg::LK_SINGLE];
    // launch on output pair, or on input pair in single clock mode
    assign launch_rise   = single ? k_rise  : lk_rise[sio_pkg::LK_C];
    assign launch_n_rise = single ? kn_rise : lk_rise[sio_pkg::LK_CN];
    assign launch_lvl    = single ? lk_f_d[sio_pkg::LK_K] : lk_f_d[sio_pkg::LK_C];
    assign din           = bus_s3_q[WORD_W-1:0];
    assign ain           = bus_s3_q[WORD_W +: ADDR_W];
    assign wr_req        = !bus_s3_q[BW-2];
    assign rd_req        = !bus_s3_q[BW-1];

    // =====================================================================
    // address slots and write path
    sio_array_if #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) arr_if ();

    logic              slot_q, slot_d;
    sio_wr_e           wst_q, wst_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d, raddr_q, raddr_d;
    logic [WORD_W-1:0] w0_q, w0_d;
    logic              we_q, we_d;

    // slots alternate on each input clock rise: read slot then write slot
    always_comb begin
        slot_d  = k_rise ? ~slot_q : slot_q;
        raddr_d = raddr_q;
        waddr_d = waddr_q;
        wst_d   = wst_q;
        w0_d    = w0_q;
        we_d    = 1'b0;
        if (k_rise && slot_q == sio_pkg::SLOT_RD && rd_req) begin
            raddr_d = ain;
        end
        unique case (wst_q)
            WR_IDLE: begin
                if (k_rise && slot_q == sio_pkg::SLOT_WR && wr_req) begin
                    waddr_d = ain;
                    wst_d   = WR_D0;
                end
            end
            WR_D0: begin
                if (k_rise) begin
                    w0_d  = din;
                    wst_d = WR_D1;
                end
            end
            WR_D1: begin
                if (kn_rise) begin
                    we_d  = 1'b1;
                    wst_d = WR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            slot_q  <= sio_pkg::SLOT_RD;
            raddr_q <= '0;
            waddr_q <= '0;
            wst_q   <= WR_IDLE;
            w0_q    <= '0;
            we_q    <= 1'b0;
        end else begin
            slot_q  <= slot_d;
            raddr_q <= raddr_d;
            waddr_q <= waddr_d;
            wst_q   <= wst_d;
            w0_q    <= w0_d;
            we_q    <= we_d;
        end
    end

    // second word rides on the request pulse itself
    logic [WORD_W-1:0] w1_q, w1_d;
    assign w1_d = (wst_q == WR_D1 && kn_rise) ? din : w1_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            w1_q <= '0;
        end else begin
            w1_q <= w1_d;
        end
    end

    assign arr_if.we     = we_q;
    assign arr_if.waddr  = waddr_q;
    assign arr_if.wdata0 = w0_q;
    assign arr_if.wdata1 = w1_q;
    assign arr_if.raddr  = raddr_q;

    sio_array #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) u_array (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .arr     (arr_if.array)
    );

    // =====================================================================
    // read launch through output registers, separate from write data in
    sio_rd_e           rst_q, rst_d;
    logic [WORD_W-1:0] q_q, q_d;
    logic              qv_q, qv_d, echo_q, echo_d, echo_n_q, echo_n_d;

    always_comb begin
        rst_d  = rst_q;
        q_q_hold: q_d = q_q;
        qv_d   = qv_q;
        echo_d = launch_lvl;
        echo_n_d = ~launch_lvl;
        if (k_rise && slot_q == sio_pkg::SLOT_RD && rd_req && rst_q == RD_IDLE) begin
            rst_d = RD_W0;
        end
        unique case (rst_q)
            RD_IDLE: begin
                qv_d = 1'b0;
            end
            RD_W0: begin
                if (launch_rise) begin
                    q_d   = arr_if.rdata0;
                    qv_d  = 1'b1;
                    rst_d = RD_W1;
                end
            end
            RD_W1: begin
                if (launch_n_rise) begin
                    q_d   = arr_if.rdata1;
                    rst_d = RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rst_q  <= RD_IDLE;
            q_q    <= '0;
            qv_q   <= 1'b0;
            echo_q <= 1'b0;
            echo_n_q <= 1'b1;
        end else begin
            rst_q  <= rst_d;
            q_q    <= q_d;
            qv_q   <= qv_d;
            echo_q <= echo_d;
            echo_n_q <= echo_n_d;
        end
    end

    assign rdata_o                 = q_q;
    assign rdata_valid_o           = qv_q;
    assign echo_clock_o            = echo_q;
    assign echo_clock_complement_o = echo_n_q;

    // =====================================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_SLOT_ALTERNATES: assert property (
        k_rise |=> slot_q != $past(slot_q)
    ) else $error("address slot did not alternate");

    AST_FALL_IGNORED: assert property (
        !k_rise |=> slot_q == $past(slot_q)
    ) else $error("slot moved without a rising edge");

    AST_WORD0_ON_RISE: assert property (
        (wst_q == WR_D0 && k_rise) |=> wst_q == WR_D1 && w0_q == $past(din)
    ) else $error("first write word not taken on input clock rise");

    AST_WRITE_AFTER_WORD1: assert property (
        (wst_q == WR_D1 && kn_rise) |=> we_q ##1 !we_q
    ) else $error("write request not a single pulse after second word");

    AST_LAUNCH_WORD0: assert property (
        (rst_q == RD_W0 && launch_rise) |=> rdata_o == $past(arr_if.rdata0) && rdata_valid_o
    ) else $error("first read word not launched on launch edge");

    AST_LAUNCH_WORD1: assert property (
        (rst_q == RD_W1 && launch_n_rise) |=> rdata_o == $past(arr_if.rdata1)
    ) else $error("second read word not launched on complement edge");

    AST_OUT_HOLDS: assert property (
        !(launch_rise || launch_n_rise) |=> $stable(rdata_o)
    ) else $error("read data changed off a launch edge");

    AST_ECHO_TRACKS: assert property (
        ##1 echo_clock_o == $past(launch_lvl) && echo_clock_complement_o != echo_clock_o
    ) else $error("echo clocks not following launch clock");
endmodule // sio_sram
`default_nettype wire

// [shared/sio_pkg.sv]
// constants shared by the separate-port burst sram model
package sio_pkg;
    // =====================================================================
    // array shape
    localparam int BURST_LEN   = 2;   // words moved per address
    localparam int WORD_W_DEF  = 36;
    localparam int ADDR_W_X8   = 22;  // 4M locations
    localparam int ADDR_W_X18  = 21;  // 2M locations
    localparam int ADDR_W_X36  = 20;  // 1M locations
    // =====================================================================
    // link sampling and timing
    localparam int SYNC_STAGES = 3;
    localparam int FMAX_MHZ    = 300; // fastest input clock
    localparam int MCLK_MHZ    = 200;
    // link clock bit order in the sampled vector
    localparam int LK_K        = 0;
    localparam int LK_KN       = 1;
    localparam int LK_C        = 2;
    localparam int LK_CN       = 3;
    localparam int LK_SINGLE   = 4;
    localparam int LK_W        = 5;
    // idle pin levels, complement clocks rest high, so no false edge after reset
    localparam logic [LK_W-1:0] LK_IDLE = 5'h0a;
    // slot codes on the shared address bus
    localparam logic SLOT_RD   = 1'b0;
    localparam logic SLOT_WR   = 1'b1;

    // address width that matches a word width
    function automatic int addr_w_for(input int word_w);
        if (word_w <= 9) begin
            return ADDR_W_X8;
        end
        return (word_w <= 18) ? ADDR_W_X18 : ADDR_W_X36;
    endfunction
endpackage

// [shared/sio_array_if.sv]
// carrier between the link front end and the storage array
`timescale 1ns/1ps
`default_nettype none
interface sio_array_if #(
    parameter int WORD_W = 36,
    parameter int ADDR_W = 20
);
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [WORD_W-1:0] wdata0;
    logic [WORD_W-1:0] wdata1;
    logic [ADDR_W-1:0] raddr;
    logic [WORD_W-1:0] rdata0;
    logic [WORD_W-1:0] rdata1;

    modport ctrl  (output we, waddr, wdata0, wdata1, raddr, input rdata0, rdata1);
    modport array (input we, waddr, wdata0, wdata1, raddr, output rdata0, rdata1);
endinterface
`default_nettype wire

// [logic/sio_array.sv]
// storage array with self-timed write commit and registered read
`timescale 1ns/1ps
`default_nettype none
module sio_array #(
    parameter int WORD_W = 36,
    parameter int ADDR_W = 20
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // front end side
    sio_array_if.array      arr
);
    // =====================================================================
    // storage, two words per location
    logic [2*WORD_W-1:0] mem_q [2**ADDR_W];
    logic                pend_q,  pend_d;
    logic [ADDR_W-1:0]   paddr_q, paddr_d;
    logic [2*WORD_W-1:0] pdata_q, pdata_d;
    logic [2*WORD_W-1:0] rd_q,    rd_d;

    // latch the request, commit internally one cycle later
    always_comb begin
        pend_d  = arr.we;
        paddr_d = arr.we ? arr.waddr : paddr_q;
        pdata_d = arr.we ? {arr.wdata1, arr.wdata0} : pdata_q;
        rd_d    = mem_q[arr.raddr];
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pend_q  <= 1'b0;
            paddr_q <= '0;
            pdata_q <= '0;
            rd_q    <= '0;
        end else begin
            pend_q  <= pend_d;
            paddr_q <= paddr_d;
            pdata_q <= pdata_d;
            rd_q    <= rd_d;
        end
    end

    // array cells have no reset, contents are undefined at power up
    always_ff @(posedge mclk_i) begin
        if (pend_q) begin
            mem_q[paddr_q] <= pdata_q;
        end
    end

    assign arr.rdata0 = rd_q[WORD_W-1:0];
    assign arr.rdata1 = rd_q[2*WORD_W-1:WORD_W];

    // =====================================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_SELF_TIMED_COMMIT: assert property (
        arr.we |=> pend_q && paddr_q == $past(arr.waddr)
    ) else $error("write not committed one cycle after request");

    AST_BURST_PAIR: assert property (
        arr.we |=> pdata_q == {$past(arr.wdata1), $past(arr.wdata0)}
    ) else $error("burst words not held as one pair");
endmodule // sio_array
`default_nettype wire

// [tb/sio_ctrl_model.sv]
// controller model: link clocks, shared address, write words and read capture
`timescale 1ns/1ps
`default_nettype none
module sio_ctrl_model #(
    parameter int WORD_W = 36,
    parameter int ADDR_W = 20
) (
    // core clock and read side of the sram
    input  wire logic              mclk_i,
    input  wire logic              single_i,
    input  wire logic [WORD_W-1:0] rdata_i,
    input  wire logic              rdata_valid_i,
    input  wire logic              echo_i,
    // link pins toward the sram
    output logic                   in_clk_o,
    output logic                   in_clk_n_o,
    output logic                   out_clk_o,
    output logic                   out_clk_n_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   rd_req_n_o,
    output logic                   wr_req_n_o,
    output logic      [WORD_W-1:0] wdata_o
);
    logic              slot_wr;     // next input clock rise is a write slot
    logic [WORD_W:0]   cap_words[$];
    logic [WORD_W-1:0] last_word;
    logic              was_valid;

    // idle pins, clocks standing still until the first period
    initial begin
        slot_wr     = 1'b0;
        was_valid   = 1'b0;
        in_clk_o    = 1'b0;
        in_clk_n_o  = 1'b1;
        out_clk_o   = 1'b0;
        out_clk_n_o = 1'b1;
        addr_o      = '0;
        rd_req_n_o  = 1'b1;
        wr_req_n_o  = 1'b1;
        wdata_o     = '0;
    end

    // one 64 ns period: pins settle 16 ns before each rising edge and hold 16 ns after
    task automatic cyc(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d0, input logic [WORD_W-1:0] d1);
        addr_o      <= a;
        rd_req_n_o  <= rd_n;
        wr_req_n_o  <= wr_n;
        wdata_o     <= d0;
        #16;
        in_clk_o    <= 1'b1;
        in_clk_n_o  <= 1'b0;
        #16;
        addr_o      <= ~a;                // released bus shows the inverse
        rd_req_n_o  <= 1'b1;
        wr_req_n_o  <= 1'b1;
        wdata_o     <= d1;
        #8;
        out_clk_o   <= !single_i;         // output pair stands still in single mode
        out_clk_n_o <= single_i;
        #8;
        in_clk_o    <= 1'b0;
        in_clk_n_o  <= 1'b1;
        #16;
        out_clk_o   <= 1'b0;
        out_clk_n_o <= 1'b1;
        slot_wr     = !slot_wr;
    endtask

    // a period with no request, data lines flipped
    task automatic idle();
        cyc(1'b1, 1'b1, ~addr_o, ~wdata_o, wdata_o);
    endtask

    // record each new read word while valid, with the echo level beside it
    always @(posedge mclk_i) begin
        if (rdata_valid_i === 1'b1 && (!was_valid || rdata_i !== last_word)) begin
            cap_words.push_back({echo_i, rdata_i});
        end
        was_valid = (rdata_valid_i === 1'b1);
        last_word = rdata_i;
    end
endmodule // sio_ctrl_model
`default_nettype wire

// [tb/separate_io_sram_two_word_burst_bench.sv]
// self-checking bench for the separate-port two-word burst sram front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end
module separate_io_sram_two_word_burst_bench;
    localparam int              WW    = sio_pkg::WORD_W_DEF;
    localparam int              AW    = sio_pkg::ADDR_W_X36;
    localparam logic [AW-1:0]   ADR_A = 20'h0_0005;
    localparam logic [AW-1:0]   ADR_B = 20'hf_ffff;
    localparam logic [AW-1:0]   ADR_C = 20'h0_0000;
    localparam logic [WW-1:0]   D_A0  = 36'h1_2345_6789;
    localparam logic [WW-1:0]   D_A1  = 36'h9_8765_4321;
    localparam logic [WW-1:0]   D_B0  = 36'hf_0f0f_0f0f;
    localparam logic [WW-1:0]   D_B1  = 36'h0_f0f0_f0f0;
    localparam logic [WW-1:0]   D_C0  = 36'ha_5a5a_5a5a;
    localparam logic [WW-1:0]   D_C1  = 36'h5_a5a5_a5a5;
    // =====================================================================
    // signals and counters
    logic          mclk = 1'b0;
    logic          rst_n;
    logic          single_mode;
    logic          in_clk, in_clk_n, out_clk, out_clk_n, rd_req_n, wr_req_n;
    logic [AW-1:0] addr;
    logic [WW-1:0] wdata, rdata;
    logic          rdata_valid, echo, echo_n;
    int            n_mismatch;
    int            n_checks;

    // 200 MHz core clock
    always #2.5 mclk = ~mclk;

    // =====================================================================
    // design and controller model
    sio_sram #(.WORD_W(WW), .ADDR_W(AW)) dut_u (
        .mclk_i(mclk), .rst_n_i(rst_n), .in_clk_i(in_clk), .in_clk_n_i(in_clk_n),
        .out_clk_i(out_clk), .out_clk_n_i(out_clk_n), .single_clk_mode_i(single_mode),
        .addr_i(addr), .rd_req_n_i(rd_req_n), .wr_req_n_i(wr_req_n), .wdata_i(wdata),
        .rdata_o(rdata), .rdata_valid_o(rdata_valid), .echo_clock_o(echo),
        .echo_clock_complement_o(echo_n));
    sio_ctrl_model #(.WORD_W(WW), .ADDR_W(AW)) mdl_u (
        .mclk_i(mclk), .single_i(single_mode), .rdata_i(rdata),
        .rdata_valid_i(rdata_valid), .echo_i(echo), .in_clk_o(in_clk),
        .in_clk_n_o(in_clk_n), .out_clk_o(out_clk), .out_clk_n_o(out_clk_n),
        .addr_o(addr), .rd_req_n_o(rd_req_n), .wr_req_n_o(wr_req_n), .wdata_o(wdata));

    // =====================================================================
    // transfers: address in the write slot, both words in the period after it
    task automatic wr(input logic [AW-1:0] a, input logic [WW-1:0] w0,
                      input logic [WW-1:0] w1);
        if (!mdl_u.slot_wr) mdl_u.idle();
        mdl_u.cyc(1'b1, 1'b0, a, ~w0, ~w1);
        mdl_u.cyc(1'b1, 1'b1, ~a, w0, w1);
    endtask

    // read address in the read slot
    task automatic rd(input logic [AW-1:0] a);
        if (mdl_u.slot_wr) mdl_u.idle();
        mdl_u.cyc(1'b0, 1'b1, a, ~mdl_u.wdata_o, mdl_u.wdata_o);
    endtask

    // pop one captured burst and compare words and echo level
    task automatic take_burst(input logic [WW-1:0] w0, input logic [WW-1:0] w1);
        logic [WW:0] g0;
        logic [WW:0] g1;
        g0 = 'x;
        g1 = 'x;
        if (mdl_u.cap_words.size() >= 2) begin
            g0 = mdl_u.cap_words.pop_front();
            g1 = mdl_u.cap_words.pop_front();
        end
        `CHK("first read word, echo high", {1'b1, w0}, g0)
        `CHK("second read word, echo low", {1'b0, w1}, g1)
        `CHK("echo complement", ~echo, echo_n)
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset();
        `CHK("read data at reset", {WW{1'b0}}, rdata)
        `CHK("valid at reset", 1'b0, rdata_valid)
        `CHK("echo at reset", 1'b0, echo)
        `CHK("echo complement at reset", 1'b1, echo_n)
        $display("test reset done");
    endtask

    task automatic t_write_read();
        mdl_u.cap_words.delete();
        wr(ADR_A, D_A0, D_A1);
        rd(ADR_A);
        mdl_u.idle();
        mdl_u.idle();
        take_burst(D_A0, D_A1);
        $display("test write_read done");
    endtask

    task automatic t_back_to_back();
        mdl_u.cap_words.delete();
        wr(ADR_B, D_B0, D_B1);
        wr(ADR_C, D_C0, D_C1);
        rd(ADR_B);
        rd(ADR_C);
        mdl_u.idle();
        mdl_u.idle();
        take_burst(D_B0, D_B1);
        take_burst(D_C0, D_C1);
        $display("test back_to_back done");
    endtask

    task automatic t_slots();
        mdl_u.cap_words.delete();
        if (!mdl_u.slot_wr) mdl_u.idle();
        mdl_u.cyc(1'b0, 1'b1, ADR_A, ~mdl_u.wdata_o, mdl_u.wdata_o);
        mdl_u.cyc(1'b1, 1'b0, ADR_B, D_A0, D_A1);
        mdl_u.idle();
        mdl_u.idle();
        `CHK("words after wrong-slot read", 0, mdl_u.cap_words.size())
        rd(ADR_B);
        mdl_u.idle();
        mdl_u.idle();
        take_burst(D_B0, D_B1);
        $display("test slots done");
    endtask

    task automatic t_single();
        @(posedge mclk);
        single_mode <= 1'b1;
        mdl_u.idle();
        mdl_u.idle();
        mdl_u.cap_words.delete();
        rd(ADR_C);
        mdl_u.idle();
        mdl_u.idle();
        take_burst(D_C0, D_C1);
        @(posedge mclk);
        single_mode <= 1'b0;
        $display("test single done");
    endtask

    // =====================================================================
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        n_mismatch  = 0;
        n_checks    = 0;
        rst_n       = 1'b0;
        single_mode = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset();
        t_write_read();
        t_back_to_back();
        t_slots();
        t_single();
        results();
    end

    // watchdog: the sequence needs about two microseconds, allow some twenty-five times that
    initial begin
        #50000;
        n_mismatch++;
        results();
    end
endmodule // separate_io_sram_two_word_burst_bench
`default_nettype wire
